// ===== hw/ipm_power_ctrl.sv
// idle/sleep power-mode controller with apb registers
// Operation
// - sleep with idle bit clear: full sleep
// - sleep with idle bit set: idle
// - idle halts cpu and program memory
// - system-clock peripherals run idle, stop sleep
// - clock output keeps running in idle
// - any interrupt ends idle, idle bit kept
// - later sleep re-enters idle while bit set
// - recover-on-interrupt wake from idle ends reduced_rate_cpu_mode mode
// - watchdog wakes idle instead of resetting
// - watchdog wakes sleep the same way
// - watchdog wake leaves reduced_rate_cpu_mode bit alone
// - sleep entry clears watchdog, other resets untouched
// - sleep entry clears power-down, sets time-out
// - sleep stops cpu and system clocks
// - requested or forced oscillators keep running
// - sleep aborts adc unless on rc clock
// - idle pins hold state in sleep
// - wake executes the following instruction first
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ipm_consts.svh"
module ipm_power_ctrl #(parameter int NPIN = 8)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sleep_exec,
  input wire logic irq_pending,
  input wire logic wdt_timeout,
  input wire logic wdt_sleep_on,
  input wire logic clock_output_enable_n,
  input wire logic fast_osc_req,
  input wire logic slow_osc_req,
  input wire logic sec_osc_req,
  input wire logic adc_dedicated_rc_osc,
  input wire logic adc_module_on,
  input wire logic [NPIN-1:0] io_periph_active,
  input wire logic [NPIN-1:0] io_out_d,
  input wire logic [NPIN-1:0] io_oe_d,
  output logic cpu_clk_en,
  output logic pmem_en,
  output logic sys_clk_en,
  output logic fosc_periph_en,
  output logic fast_osc_en,
  output logic slow_osc_en,
  output logic sec_osc_en,
  output logic clock_output_enable_n_en,
  output logic wdt_clear,
  output logic wdt_run,
  output logic wdt_reset_block,
  output logic power_down_flag_n,
  output logic timeout_flag_n,
  output logic adc_abort,
  output logic adc_power_off,
  output logic reduced_rate_cpu_mode,
  output logic exec_next_first,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic irq
);
  ipm_pkg::ipm_mode_e mode;
  ipm_pkg::ipm_mode_e next_mode;
  logic [`IPM_CTRL_W-1:0] ctrl;
  logic [2:0] osc_req_s;
  logic acc;
  logic wr;
  logic wr_ctrl;
  logic enter_sleep;
  logic enter_idle;
  logic wake_irq;
  logic wake_wdt;
  logic roi_wake;
  logic [`IPM_EVT_W-1:0] evt;
  logic [NPIN-1:0] hold_mask;
  ipm_evt_if ev ();

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  // oscillator requests come from peripherals on their own clocks
  ipm_sync #(.W(3)) u_sync
  (
    .clk(pclk),
    .rst_n(presetn),
    .d({sec_osc_req, slow_osc_req, fast_osc_req}),
    .q(osc_req_s)
  );

  ipm_irq u_irq
  (
    .clk(pclk),
    .rst_n(presetn),
    .bus(ev),
    .irq(irq)
  );

  // apb: one wait state, writes land at the edge that sees pready
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign wr_ctrl = wr & hit(paddr, `IPM_CTRL_OFF);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pready <= `IPM_OFF;
    else
      pready <= psel & penable & ~pready;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= '0;
      pslverr <= `IPM_OFF;
    end
    else if (psel & penable & ~pready)
    begin
      prdata <= '0;
      pslverr <= `IPM_OFF;
      if (hit(paddr, `IPM_CTRL_OFF))
        prdata[`IPM_CTRL_W-1:0] <= ctrl;
      else if (hit(paddr, `IPM_STAT_OFF))
        prdata[`IPM_STAT_W-1:0] <= {reduced_rate_cpu_mode, timeout_flag_n,
                                    power_down_flag_n, mode == ipm_pkg::mode_sleep,
                                    mode == ipm_pkg::mode_idle};
      else if (hit(paddr, `IPM_ISTAT_OFF))
        prdata[`IPM_EVT_W-1:0] <= ev.stat;
      else if (hit(paddr, `IPM_IMASK_OFF))
        prdata[`IPM_EVT_W-1:0] <= ev.mask;
      else
        pslverr <= `IPM_EN_RST;
    end
  end

  assign ev.stat_wr = wr & hit(paddr, `IPM_ISTAT_OFF);
  assign ev.mask_wr = wr & hit(paddr, `IPM_IMASK_OFF);
  assign ev.wdata = pwdata[`IPM_EVT_W-1:0];
  assign ev.evt = evt;

  // mode decision; an interrupt outranks a watchdog wake in the same cycle
  assign enter_sleep = (mode == ipm_pkg::mode_run) & sleep_exec & ~ctrl[`IPM_CTRL_IDLE];
  assign enter_idle = (mode == ipm_pkg::mode_run) & sleep_exec & ctrl[`IPM_CTRL_IDLE];
  assign wake_irq = (mode != ipm_pkg::mode_run) & irq_pending;
  assign wake_wdt = (mode != ipm_pkg::mode_run) & wdt_timeout & ~irq_pending;
  assign roi_wake = (mode == ipm_pkg::mode_idle) & wake_irq
                    & ctrl[`IPM_CTRL_ROI] & ctrl[`IPM_CTRL_REDUCED_RATE_CPU_MODE];
  assign evt = {wake_wdt, wake_irq, enter_idle, enter_sleep};

  always_comb
  begin
    next_mode = mode;
    case (mode)
      ipm_pkg::mode_run:
      begin
        if (enter_idle)
          next_mode = ipm_pkg::mode_idle;
        else if (enter_sleep)
          next_mode = ipm_pkg::mode_sleep;
      end
      ipm_pkg::mode_idle,
      ipm_pkg::mode_sleep:
      begin
        if (wake_irq | wake_wdt)
          next_mode = ipm_pkg::mode_run;
      end
      default: next_mode = ipm_pkg::mode_run;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mode <= ipm_pkg::mode_run;
    else
      mode <= next_mode;
  end

  // control bits; a recover-on-interrupt wake beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl <= `IPM_CTRL_RST;
    else
    begin
      if (wr_ctrl)
        ctrl <= pwdata[`IPM_CTRL_W-1:0];
      if (roi_wake)
        ctrl[`IPM_CTRL_REDUCED_RATE_CPU_MODE] <= `IPM_OFF;
    end
  end

  // clock gates follow next_mode so they line up with mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_clk_en <= `IPM_EN_RST;
      pmem_en <= `IPM_EN_RST;
      sys_clk_en <= `IPM_EN_RST;
      fosc_periph_en <= `IPM_EN_RST;
      clock_output_enable_n_en <= `IPM_OFF;
    end
    else
    begin
      cpu_clk_en <= next_mode == ipm_pkg::mode_run;
      pmem_en <= next_mode == ipm_pkg::mode_run;
      sys_clk_en <= next_mode != ipm_pkg::mode_sleep;
      fosc_periph_en <= next_mode != ipm_pkg::mode_sleep;
      clock_output_enable_n_en <= ~clock_output_enable_n & (next_mode != ipm_pkg::mode_sleep);
    end
  end

  // internal oscillators stay up awake; asleep only when asked or forced
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fast_osc_en <= `IPM_EN_RST;
      slow_osc_en <= `IPM_EN_RST;
      sec_osc_en <= `IPM_EN_RST;
    end
    else if (next_mode == ipm_pkg::mode_sleep)
    begin
      fast_osc_en <= osc_req_s[0] | ctrl[`IPM_CTRL_FFORCE];
      slow_osc_en <= osc_req_s[1] | ctrl[`IPM_CTRL_SFORCE];
      sec_osc_en <= osc_req_s[2] | ctrl[`IPM_CTRL_XFORCE];
    end
    else
    begin
      fast_osc_en <= `IPM_EN_RST;
      slow_osc_en <= `IPM_EN_RST;
      sec_osc_en <= `IPM_EN_RST;
    end
  end

  // watchdog: cleared on sleep entry, reset turned into a wake while low power
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wdt_clear <= `IPM_OFF;
      wdt_run <= `IPM_EN_RST;
      wdt_reset_block <= `IPM_OFF;
    end
    else
    begin
      wdt_clear <= enter_sleep;
      wdt_run <= (next_mode != ipm_pkg::mode_sleep) | wdt_sleep_on;
      wdt_reset_block <= next_mode != ipm_pkg::mode_run;
    end
  end

  // status flags; only sleep entry touches them here
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      power_down_flag_n <= `IPM_FLAG_RST;
      timeout_flag_n <= `IPM_FLAG_RST;
    end
    else if (enter_sleep)
    begin
      power_down_flag_n <= `IPM_OFF;
      timeout_flag_n <= `IPM_FLAG_RST;
    end
  end

  // the adc enable bit itself is not ours; only the power and abort lines are
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      adc_abort <= `IPM_OFF;
      adc_power_off <= `IPM_OFF;
    end
    else
    begin
      adc_abort <= enter_sleep & adc_module_on & ~adc_dedicated_rc_osc;
      if (enter_sleep)
        adc_power_off <= ~adc_dedicated_rc_osc;
      else if (next_mode != ipm_pkg::mode_sleep)
        adc_power_off <= `IPM_OFF;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      reduced_rate_cpu_mode <= `IPM_OFF;
      exec_next_first <= `IPM_OFF;
    end
    else
    begin
      reduced_rate_cpu_mode <= ctrl[`IPM_CTRL_REDUCED_RATE_CPU_MODE] & ~roi_wake;
      exec_next_first <= (mode != ipm_pkg::mode_run)
                         & (next_mode == ipm_pkg::mode_run);
    end
  end

  // pins with no active peripheral freeze while asleep
  assign hold_mask = {NPIN{mode == ipm_pkg::mode_sleep}} & ~io_periph_active;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_out <= '0;
      pin_oe <= '0;
    end
    else
    begin
      pin_out <= (hold_mask & pin_out) | (~hold_mask & io_out_d);
      pin_oe <= (hold_mask & pin_oe) | (~hold_mask & io_oe_d);
    end
  end

  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_run && sleep_exec && !ctrl[`IPM_CTRL_IDLE]
    |=> mode == ipm_pkg::mode_sleep ##1 sys_clk_en == 1'b0 || mode == ipm_pkg::mode_run)
    else $error("sleep not entered");

  a_idle_entry: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_run && sleep_exec && ctrl[`IPM_CTRL_IDLE]
    |=> mode == ipm_pkg::mode_idle)
    else $error("idle not entered");

  a_idle_gates: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_idle |-> !cpu_clk_en && !pmem_en && fosc_periph_en && sys_clk_en)
    else $error("idle clock gates wrong");

  a_clock_output_enable_n_idle: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_idle && !$past(clock_output_enable_n) |-> clock_output_enable_n_en)
    else $error("clock output stopped in idle");

  a_irq_wake: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_idle && irq_pending && !wr_ctrl
    |=> mode == ipm_pkg::mode_run && $stable(ctrl[`IPM_CTRL_IDLE]) && exec_next_first)
    else $error("interrupt wake from idle wrong");

  a_roi_restore: assert property (@(posedge pclk) disable iff (!presetn)
    roi_wake |=> !ctrl[`IPM_CTRL_REDUCED_RATE_CPU_MODE] && !reduced_rate_cpu_mode)
    else $error("reduced_rate_cpu_mode not ended by interrupt wake");

  a_wdt_wake: assert property (@(posedge pclk) disable iff (!presetn)
    mode != ipm_pkg::mode_run && wdt_timeout && !irq_pending && !wr_ctrl
    |=> mode == ipm_pkg::mode_run && $stable(ctrl[`IPM_CTRL_REDUCED_RATE_CPU_MODE]))
    else $error("watchdog wake wrong");

  a_sleep_flags: assert property (@(posedge pclk) disable iff (!presetn)
    enter_sleep |=> !power_down_flag_n && timeout_flag_n && wdt_clear ##1 !wdt_clear)
    else $error("sleep entry flags wrong");

  a_sleep_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_sleep |-> !cpu_clk_en && !sys_clk_en && !fosc_periph_en)
    else $error("clocks running in sleep");

  a_osc_keep: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_sleep && ($past(osc_req_s[0]) || $past(ctrl[`IPM_CTRL_FFORCE]))
    |-> fast_osc_en)
    else $error("fast oscillator dropped");

  a_adc_abort: assert property (@(posedge pclk) disable iff (!presetn)
    enter_sleep && adc_module_on |=> adc_abort == !$past(adc_dedicated_rc_osc))
    else $error("adc abort wrong");

  a_pin_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mode == ipm_pkg::mode_sleep && !io_periph_active[NPIN-1] |=> $stable(pin_out[NPIN-1]))
    else $error("pin changed in sleep");
endmodule : ipm_power_ctrl
`default_nettype wire

// ===== hw/ipm_consts.svh
// register map, field positions and reset values of the idle/sleep controller
`ifndef IPM_CONSTS_SVH
`define IPM_CONSTS_SVH
`define IPM_CTRL_OFF 8'h00
`define IPM_STAT_OFF 8'h04
`define IPM_ISTAT_OFF 8'h08
`define IPM_IMASK_OFF 8'h0c
`define IPM_CTRL_W 6
`define IPM_CTRL_RST 6'h00
`define IPM_CTRL_IDLE 0
`define IPM_CTRL_ROI 1
`define IPM_CTRL_REDUCED_RATE_CPU_MODE 2
`define IPM_CTRL_FFORCE 3
`define IPM_CTRL_SFORCE 4
`define IPM_CTRL_XFORCE 5
`define IPM_STAT_W 5
`define IPM_EVT_W 4
`define IPM_EVT_RST 4'h0
`define IPM_EVT_SLEEP 0
`define IPM_EVT_IDLE 1
`define IPM_EVT_IRQW 2
`define IPM_EVT_WDTW 3
`define IPM_FLAG_RST 1'b1
`define IPM_EN_RST 1'b1
`define IPM_OFF 1'b0
`endif

// ===== hw/ipm_pkg.sv
// types shared by the idle/sleep controller modules
package ipm_pkg;
  typedef enum logic [1:0] {mode_run, mode_idle, mode_sleep} ipm_mode_e;
endpackage : ipm_pkg

// ===== hw/ipm_evt_if.sv
// event and register traffic between the controller and its interrupt unit
`timescale 1ns/10ps
`default_nettype none
`include "ipm_consts.svh"
interface ipm_evt_if;
  logic [`IPM_EVT_W-1:0] evt;
  logic stat_wr;
  logic mask_wr;
  logic [`IPM_EVT_W-1:0] wdata;
  logic [`IPM_EVT_W-1:0] stat;
  logic [`IPM_EVT_W-1:0] mask;
  modport ctrl_side (output evt, stat_wr, mask_wr, wdata, input stat, mask);
  modport irq_side (input evt, stat_wr, mask_wr, wdata, output stat, mask);
endinterface : ipm_evt_if
`default_nettype wire

// ===== hw/ipm_sync.sv
// two-stage synchroniser for levels from other clock domains
`timescale 1ns/10ps
`default_nettype none
module ipm_sync #(parameter int W = 1)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : ipm_sync
`default_nettype wire

// ===== hw/ipm_irq.sv
// sticky event status, mask and level interrupt of the controller
`timescale 1ns/10ps
`default_nettype none
`include "ipm_consts.svh"
module ipm_irq
(
  input wire logic clk,
  input wire logic rst_n,
  ipm_evt_if.irq_side bus,
  output logic irq
);
  // a new event wins over a write-one-to-clear in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.stat <= `IPM_EVT_RST;
    else if (bus.stat_wr)
      bus.stat <= (bus.stat & ~bus.wdata) | bus.evt;
    else
      bus.stat <= bus.stat | bus.evt;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bus.mask <= `IPM_EVT_RST;
    else if (bus.mask_wr)
      bus.mask <= bus.wdata;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq <= `IPM_OFF;
    else
      irq <= |(bus.stat & bus.mask);
  end
endmodule : ipm_irq
`default_nettype wire

// ===== test/ipm_core_model.sv
// behavioural processor core that issues sleep and raises wake sources
`timescale 1ns/10ps
`default_nettype none
module ipm_core_model
(
  input wire logic pclk,
  input wire logic cpu_clk_en,
  input wire logic exec_next_first,
  output logic sleep_exec,
  output logic irq_pending,
  output logic wdt_timeout
);
  int resumed = 0;
  initial
  begin
    sleep_exec = 1'b0;
    irq_pending = 1'b0;
    wdt_timeout = 1'b0;
  end
  // counts resumptions so the bench can see the wake pulse
  always @(posedge pclk)
    if (exec_next_first === 1'b1)
      resumed <= resumed + 1;
  task automatic sleep_instr;
    @(posedge pclk);
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
  endtask : sleep_instr
  // a pending interrupt stays up until the core runs again, as a real one would
  task automatic wake(input logic by_wdt, output bit ok);
    int i;
    ok = 1'b0;
    @(posedge pclk);
    if (by_wdt)
      wdt_timeout <= 1'b1;
    else
      irq_pending <= 1'b1;
    @(posedge pclk);
    wdt_timeout <= 1'b0;
    for (i = 0; i < 20 && !ok; i++)
    begin
      @(negedge pclk);
      ok = (cpu_clk_en === 1'b1);
    end
    @(posedge pclk);
    irq_pending <= 1'b0;
  endtask : wake
endmodule : ipm_core_model
`default_nettype wire

// ===== test/testbench.sv
// self-checking bench of the idle/sleep power-mode controller
`timescale 1ns/10ps
`default_nettype none
`include "ipm_consts.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic pready, pslverr, e, sleep_exec, irq_pending, wdt_timeout;
  logic wdt_sleep_on = 1'b1, clock_output_enable_n = 1'b1;
  logic fast_osc_req = 1'b0, slow_osc_req = 1'b0, sec_osc_req = 1'b0;
  logic adc_dedicated_rc_osc = 1'b0, adc_module_on = 1'b1;
  logic [7:0] io_periph_active = 8'h00, io_out_d = 8'h00, io_oe_d = 8'h00;
  logic cpu_clk_en, pmem_en, sys_clk_en, fosc_periph_en, fast_osc_en, slow_osc_en;
  logic sec_osc_en, clock_output_enable_n_en, wdt_clear, wdt_run, wdt_reset_block, power_down_flag_n;
  logic timeout_flag_n, adc_abort, adc_power_off, reduced_rate_cpu_mode, exec_next_first;
  logic [7:0] pin_out, pin_oe;
  logic irq;
  bit ok;
  int error_cnt = 0, num_checks = 0, n_clr = 0, n_abort = 0;
  ipm_power_ctrl #(.NPIN(8)) i_ipm_power_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sleep_exec(sleep_exec), .irq_pending(irq_pending),
    .wdt_timeout(wdt_timeout), .wdt_sleep_on(wdt_sleep_on),
    .clock_output_enable_n(clock_output_enable_n), .fast_osc_req(fast_osc_req),
    .slow_osc_req(slow_osc_req), .sec_osc_req(sec_osc_req),
    .adc_dedicated_rc_osc(adc_dedicated_rc_osc), .adc_module_on(adc_module_on),
    .io_periph_active(io_periph_active), .io_out_d(io_out_d), .io_oe_d(io_oe_d),
    .cpu_clk_en(cpu_clk_en), .pmem_en(pmem_en), .sys_clk_en(sys_clk_en),
    .fosc_periph_en(fosc_periph_en), .fast_osc_en(fast_osc_en), .slow_osc_en(slow_osc_en),
    .sec_osc_en(sec_osc_en), .clock_output_enable_n_en(clock_output_enable_n_en), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
    .wdt_reset_block(wdt_reset_block), .power_down_flag_n(power_down_flag_n),
    .timeout_flag_n(timeout_flag_n), .adc_abort(adc_abort), .adc_power_off(adc_power_off),
    .reduced_rate_cpu_mode(reduced_rate_cpu_mode), .exec_next_first(exec_next_first),
    .pin_out(pin_out), .pin_oe(pin_oe), .irq(irq));
  ipm_core_model u_core (.pclk(pclk), .cpu_clk_en(cpu_clk_en),
    .exec_next_first(exec_next_first), .sleep_exec(sleep_exec),
    .irq_pending(irq_pending), .wdt_timeout(wdt_timeout));
  initial
  begin
    forever #2.5 pclk = ~pclk;
  end
  // one-cycle pulses are counted here so no check depends on landing in their cycle
  always @(posedge pclk)
  begin
    if (wdt_clear === 1'b1)
      n_clr <= n_clr + 1;
    if (adc_abort === 1'b1)
      n_abort <= n_abort + 1;
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  // read data and error are taken at the edge where pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd, output logic err);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 16)
    begin
      error_cnt++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic settle;
    repeat (3) @(negedge pclk);
  endtask : settle
  task automatic t_reset;
    `CHK({cpu_clk_en, pmem_en, sys_clk_en, wdt_run, clock_output_enable_n_en}, 5'h1e)
    `CHK({power_down_flag_n, timeout_flag_n, irq}, 3'h6)
    apb(1'b0, `IPM_CTRL_OFF, 32'h0, d, e);
    `CHK(d, 32'h0)
    apb(1'b0, `IPM_STAT_OFF, 32'h0, d, e);
    `CHK(d, 32'h0000000c)
    apb(1'b1, 8'h10, 32'hffffffff, d, e);
    apb(1'b0, 8'h10, 32'h0, d, e);
    `CHK({e, d}, {1'b1, 32'h0})
  endtask : t_reset
  task automatic t_sleep;
    apb(1'b1, `IPM_CTRL_OFF, 32'h00000020, d, e);
    fast_osc_req <= 1'b1;
    io_out_d <= 8'h5a;
    io_oe_d <= 8'hff;
    io_periph_active <= 8'h0f;
    settle();
    u_core.sleep_instr();
    settle();
    @(posedge pclk);
    io_out_d <= 8'ha5;
    io_oe_d <= 8'h00;
    settle();
    `CHK({cpu_clk_en, sys_clk_en, pmem_en}, 3'h0)
    `CHK(fosc_periph_en, 1'b0)
    `CHK({power_down_flag_n, timeout_flag_n}, 2'h1)
    `CHK({n_clr, wdt_run, wdt_reset_block}, {32'sd1, 2'h3})
    `CHK({n_abort, adc_power_off}, {32'sd1, 1'b1})
    `CHK({fast_osc_en, slow_osc_en, sec_osc_en}, 3'h5)
    `CHK({pin_out, pin_oe}, {8'h55, 8'hf0})
    apb(1'b0, `IPM_STAT_OFF, 32'h0, d, e);
    `CHK(d, 32'h0000000a)
    wdt_sleep_on <= 1'b0;
    settle();
    `CHK(wdt_run, 1'b0)
    @(posedge pclk);
    wdt_sleep_on <= 1'b1;
    u_core.wake(1'b1, ok);
    settle();
    `CHK(ok, 1'b1)
    `CHK(u_core.resumed, 1)
    `CHK({fast_osc_en, slow_osc_en, sec_osc_en, adc_power_off}, 4'he)
  endtask : t_sleep
  task automatic t_idle;
    @(posedge pclk);
    adc_dedicated_rc_osc <= 1'b1;
    clock_output_enable_n <= 1'b0;
    apb(1'b1, `IPM_CTRL_OFF, 32'h00000001, d, e);
    u_core.sleep_instr();
    settle();
    `CHK({cpu_clk_en, pmem_en}, 2'h0)
    `CHK(fosc_periph_en, 1'b1)
    `CHK(clock_output_enable_n_en, 1'b1)
    `CHK({n_abort, adc_power_off}, {32'sd1, 1'b0})
    u_core.wake(1'b0, ok);
    `CHK(ok, 1'b1)
    apb(1'b0, `IPM_CTRL_OFF, 32'h0, d, e);
    `CHK(d, 32'h00000001)
    u_core.sleep_instr();
    settle();
    `CHK({cpu_clk_en, fosc_periph_en}, 2'h1)
    u_core.wake(1'b0, ok);
  endtask : t_idle
  task automatic t_reduced_rate_cpu_mode;
    apb(1'b1, `IPM_CTRL_OFF, 32'h00000007, d, e);
    settle();
    `CHK(reduced_rate_cpu_mode, 1'b1)
    u_core.sleep_instr();
    u_core.wake(1'b0, ok);
    settle();
    `CHK(reduced_rate_cpu_mode, 1'b0)
    apb(1'b1, `IPM_CTRL_OFF, 32'h00000007, d, e);
    u_core.sleep_instr();
    settle();
    `CHK(wdt_reset_block, 1'b1)
    u_core.wake(1'b1, ok);
    settle();
    `CHK({ok, reduced_rate_cpu_mode}, 2'h3)
    apb(1'b0, `IPM_CTRL_OFF, 32'h0, d, e);
    `CHK(d, 32'h00000007)
  endtask : t_reduced_rate_cpu_mode
  task automatic t_irq;
    apb(1'b0, `IPM_ISTAT_OFF, 32'h0, d, e);
    `CHK({d, irq}, {32'h0000000f, 1'b0})
    apb(1'b1, `IPM_IMASK_OFF, 32'h00000008, d, e);
    settle();
    `CHK(irq, 1'b1)
    apb(1'b1, `IPM_ISTAT_OFF, 32'h00000008, d, e);
    settle();
    `CHK(irq, 1'b0)
    apb(1'b0, `IPM_ISTAT_OFF, 32'h0, d, e);
    `CHK(d, 32'h00000007)
    apb(1'b1, `IPM_STAT_OFF, 32'hffffffff, d, e);
    apb(1'b0, `IPM_STAT_OFF, 32'h0, d, e);
    `CHK(d, 32'h00000018)
  endtask : t_irq
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    t_reset();
    t_sleep();
    t_idle();
    t_reduced_rate_cpu_mode();
    t_irq();
    final_report();
  end
endmodule : testbench
`default_nettype wire
